/* File: tch_pkg.sv */
// Purpose: shared constants for the telematics command handler
// Assumes: 10 MHz system clock, 32-bit AHB-Lite register bus
// Notes:   all offsets are byte addresses of aligned words

package tch_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ         = 10_000_000;
  localparam longint DOOR_PULSE_S   = 5;
  localparam longint ANT_LOSS_S     = 30;
  localparam int     DOOR_PULSE_CYC = int'(DOOR_PULSE_S * CLK_HZ);
  localparam int     ANT_LOSS_CYC   = int'(ANT_LOSS_S * CLK_HZ);

  // ----------------------------------------------------------------
  // command identifiers
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_POSITION   = 4'h1;
  localparam logic [3:0] CMD_DOOR       = 4'h2;
  localparam logic [3:0] CMD_START_OFF  = 4'h3;
  localparam logic [3:0] CMD_START_ON   = 4'h4;
  localparam logic [3:0] CMD_FENCE1     = 4'h5;
  localparam logic [3:0] CMD_FENCE2     = 4'h6;
  localparam logic [3:0] CMD_FENCE3     = 4'h7;
  localparam logic [3:0] CMD_STATUS     = 4'h8;
  localparam logic [3:0] CMD_FENCE_OFF  = 4'h9;

  // ----------------------------------------------------------------
  // report layout
  // ----------------------------------------------------------------
  localparam int         RPT_W     = 45;
  localparam int         LAT_W     = 21;
  localparam int         LON_W     = 22;
  localparam int         SPEED_W   = 6;
  localparam int         AGE_W     = 11;
  localparam logic       ID_POS    = 1'b0;
  localparam logic       ID_STATUS = 1'b1;
  localparam logic [2:0] FENCE_NONE = 3'h0;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CMD      = 8'h00;
  localparam logic [7:0] OFS_LAT      = 8'h04;
  localparam logic [7:0] OFS_LON      = 8'h08;
  localparam logic [7:0] OFS_FIX      = 8'h0c;
  localparam logic [7:0] OFS_VEH      = 8'h10;
  localparam logic [7:0] OFS_AGE      = 8'h14;
  localparam logic [7:0] OFS_STATE    = 8'h18;
  localparam logic [7:0] OFS_ORG_LAT  = 8'h1c;
  localparam logic [7:0] OFS_ORG_LON  = 8'h20;
  localparam logic [7:0] OFS_RPT_LO   = 8'h24;
  localparam logic [7:0] OFS_RPT_HI   = 8'h28;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int VEH_BATT_LSB  = 0;
  localparam int VEH_RSSI_LSB  = 8;
  localparam int VEH_SPEED_LSB = 16;
  localparam int VEH_GPS_LSB   = 24;
  localparam logic STARTER_RST = 1'b1;

  typedef enum logic [0:0] {
    TCH_RPT_IDLE = 1'b0,
    TCH_RPT_SEND = 1'b1
  } tch_rpt_state_t;

endpackage

/* File: tch_command_handler.sv */
// Purpose: decode paged commands into relay, geo-fence and report actions
// Assumes: commands come from radio logic on clk_sys_i; pins are asynchronous
// Notes:   reports leave as one 45-bit word with a valid/ready handshake

`timescale 1ns/1ps

// Behaviour
// - command 1 queues a position report
// - position report carries 21-bit latitude and 22-bit longitude
// - every report opens with one message identifier bit
// - position report ends with fresh-fix flag, set only for a new fix
// - command 2 pulses door output high for 5 seconds
// - command 3 drives starter output low, latched
// - command 4 drives starter output high, latched
// - command 5 selects fence 1 and stores current position as origin
// - command 6 selects fence 2 and stores current position as origin
// - command 7 selects fence 3 and stores current position as origin
// - command 9 turns geo-fence monitoring off
// - command 8 queues a status report
// - status report: 8-bit battery then 8-bit signal strength
// - status report: 6-bit speed, 2.86 mph per count
// - status report: 11-bit fix age in 64-second units
// - status report: 3-bit receiver status, then 3-bit active fence
// - status report: fence violation flag
// - status report: door flag then starter flag
// - status report ends with low then high impact sensor states
// - antenna lost about 30 seconds then restored sends a status report
// - status report is exactly 45 bits; position report is also 45 bits, filling the whole 45-bit word
module tch_command_handler
  import tch_pkg::*;
#(
  parameter int DOOR_CYC = DOOR_PULSE_CYC,
  parameter int ANT_CYC  = ANT_LOSS_CYC
)(
  // clock, reset, enable
  input  wire logic              clk_sys_i,
  input  wire logic              reset_i,
  input  wire logic              ce_i,
  // ahb-lite slave
  input  wire logic              hsel_i,
  input  wire logic [31:0]       haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic [2:0]        hsize_i,
  input  wire logic [31:0]       hwdata_i,
  input  wire logic              hready_i,
  output logic [31:0]            hrdata_o,
  output logic                   hreadyout_o,
  output logic                   hresp_o,
  // paged command from radio
  input  wire logic              cmd_valid_i,
  input  wire logic [3:0]        cmd_id_i,
  // fence monitor and pins
  input  wire logic              fence_violation_i,
  input  wire logic              antenna_ok_i,
  input  wire logic              crash_low_i,
  input  wire logic              crash_high_i,
  output logic                   door_unlock_o,
  output logic                   starter_enable_o,
  // reverse channel report
  output logic                   report_valid_o,
  output logic [RPT_W-1:0]       report_data_o,
  input  wire logic              report_ready_i
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end
    else if (ce_i)
    begin
      pin_meta <= {crash_high_i, crash_low_i, antenna_ok_i};
      pin_sync <= pin_meta;
    end
  end

  logic ant_ok;
  logic crash_low;
  logic crash_high;
  assign ant_ok     = pin_sync[0];
  assign crash_low  = pin_sync[1];
  assign crash_high = pin_sync[2];

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic              dph_wr;
  logic [7:0]        dph_addr;
  logic              aph_take;
  logic              bus_cmd_pend;
  logic [3:0]        bus_cmd_id;
  logic [LAT_W-1:0]  cur_lat;
  logic [LON_W-1:0]  cur_lon;
  logic              fresh_fix;
  logic [7:0]        batt;
  logic [7:0]        rssi;
  logic [SPEED_W-1:0] speed;
  logic [2:0]        gps_stat;
  logic [AGE_W-1:0]  fix_age;

  // a stalled clock enable stalls the bus too, so no transfer is lost
  assign hreadyout_o = ce_i;
  assign hresp_o     = 1'b0;
  assign aph_take    = hsel_i && htrans_i[1] && hready_i;

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      dph_wr   <= 1'b0;
      dph_addr <= 8'h00;
    end
    else if (ce_i)
    begin
      dph_wr   <= aph_take && hwrite_i;
      dph_addr <= haddr_i[7:0];
    end
  end

  logic wr_cmd;
  logic wr_fix;
  assign wr_cmd = ce_i && dph_wr && dph_addr == OFS_CMD;
  assign wr_fix = ce_i && dph_wr && dph_addr == OFS_FIX;

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      cur_lat  <= '0;
      cur_lon  <= '0;
      batt     <= 8'h00;
      rssi     <= 8'h00;
      speed    <= '0;
      gps_stat <= 3'h0;
      fix_age  <= '0;
    end
    else if (ce_i && dph_wr)
    begin
      case (dph_addr)
        OFS_LAT: cur_lat <= hwdata_i[LAT_W-1:0];
        OFS_LON: cur_lon <= hwdata_i[LON_W-1:0];
        OFS_VEH:
        begin
          batt     <= hwdata_i[VEH_BATT_LSB +: 8];
          rssi     <= hwdata_i[VEH_RSSI_LSB +: 8];
          speed    <= hwdata_i[VEH_SPEED_LSB +: SPEED_W];
          gps_stat <= hwdata_i[VEH_GPS_LSB +: 3];
        end
        OFS_AGE: fix_age <= hwdata_i[AGE_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // command source: radio port wins, bus command waits while cmd_valid_i is high
  // ----------------------------------------------------------------
  logic       cmd_go;
  logic [3:0] cmd_id;
  assign cmd_go = cmd_valid_i || bus_cmd_pend;
  assign cmd_id = cmd_valid_i ? cmd_id_i : bus_cmd_id;

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      bus_cmd_pend <= 1'b0;
      bus_cmd_id   <= 4'h0;
    end
    else if (ce_i)
    begin
      if (wr_cmd)
      begin
        bus_cmd_pend <= 1'b1;
        bus_cmd_id   <= hwdata_i[3:0];
      end
      else if (!cmd_valid_i)
      begin
        bus_cmd_pend <= 1'b0;
      end
    end
  end

  logic [3:0] last_cmd;
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      last_cmd <= 4'h0;
    else if (ce_i && cmd_go)
      last_cmd <= cmd_id;
  end

  // ----------------------------------------------------------------
  // relays
  // ----------------------------------------------------------------
  logic [31:0] door_cnt;

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      door_unlock_o <= 1'b0;
      door_cnt      <= 32'h0;
    end
    else if (ce_i)
    begin
      if (cmd_go && cmd_id == CMD_DOOR)
      begin
        door_unlock_o <= 1'b1;
        door_cnt      <= 32'(DOOR_CYC - 1);
      end
      else if (door_cnt != 32'h0)
        door_cnt <= door_cnt - 32'h1;
      else
        door_unlock_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      starter_enable_o <= STARTER_RST;
    else if (ce_i && cmd_go)
    begin
      if (cmd_id == CMD_START_OFF)
        starter_enable_o <= 1'b0;
      else if (cmd_id == CMD_START_ON)
        starter_enable_o <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // geo-fence selection
  // ----------------------------------------------------------------
  logic [2:0]       fence_sel;
  logic [LAT_W-1:0] org_lat;
  logic [LON_W-1:0] org_lon;
  logic             fence_viol;

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      fence_sel <= FENCE_NONE;
      org_lat   <= '0;
      org_lon   <= '0;
    end
    else if (ce_i && cmd_go)
    begin
      case (cmd_id)
        CMD_FENCE1,
        CMD_FENCE2,
        CMD_FENCE3:
        begin
          fence_sel <= 3'(cmd_id - CMD_FENCE1 + 4'h1);
          org_lat   <= cur_lat;
          org_lon   <= cur_lon;
        end
        CMD_FENCE_OFF: fence_sel <= FENCE_NONE;
        default: ;
      endcase
    end
  end

  // the distance check lives outside; its verdict only counts while armed
  assign fence_viol = fence_violation_i && fence_sel != FENCE_NONE;

  // ----------------------------------------------------------------
  // antenna loss watch
  // ----------------------------------------------------------------
  logic [31:0] ant_cnt;
  logic        ant_long;
  logic        ant_restore;

  assign ant_long = ant_cnt >= 32'(ANT_CYC);

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      ant_cnt <= 32'h0;
    else if (ce_i)
    begin
      if (ant_ok)
        ant_cnt <= 32'h0;
      else if (!ant_long)
        ant_cnt <= ant_cnt + 32'h1;
    end
  end

  assign ant_restore = ant_ok && ant_long;

  // ----------------------------------------------------------------
  // report requests and packing
  // ----------------------------------------------------------------
  logic           pos_req;
  logic           stat_req;
  tch_rpt_state_t rpt_state;
  logic           load_pos;
  logic           load_stat;

  assign load_pos  = rpt_state == TCH_RPT_IDLE && pos_req;
  assign load_stat = rpt_state == TCH_RPT_IDLE && !pos_req && stat_req;

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      pos_req  <= 1'b0;
      stat_req <= 1'b0;
    end
    else if (ce_i)
    begin
      if (cmd_go && cmd_id == CMD_POSITION)
        pos_req <= 1'b1;
      else if (load_pos)
        pos_req <= 1'b0;
      if ((cmd_go && cmd_id == CMD_STATUS) || ant_restore)
        stat_req <= 1'b1;
      else if (load_stat)
        stat_req <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      fresh_fix <= 1'b0;
    else if (ce_i)
    begin
      if (wr_fix)
        fresh_fix <= hwdata_i[0];
      else if (load_pos)
        fresh_fix <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      rpt_state     <= TCH_RPT_IDLE;
      report_data_o <= '0;
    end
    else if (ce_i)
    begin
      case (rpt_state)
        TCH_RPT_IDLE:
        begin
          if (load_pos)
          begin
            report_data_o <= {ID_POS, cur_lat, cur_lon, fresh_fix};
            rpt_state     <= TCH_RPT_SEND;
          end
          else if (load_stat)
          begin
            report_data_o <= {ID_STATUS, batt, rssi, speed, fix_age,
                              gps_stat, fence_sel, fence_viol,
                              door_unlock_o, starter_enable_o,
                              crash_low, crash_high};
            rpt_state     <= TCH_RPT_SEND;
          end
        end
        TCH_RPT_SEND:
        begin
          if (report_ready_i)
            rpt_state <= TCH_RPT_IDLE;
        end
        default: rpt_state <= TCH_RPT_IDLE;
      endcase
    end
  end

  assign report_valid_o = rpt_state == TCH_RPT_SEND;

  // ----------------------------------------------------------------
  // read data, registered in the address phase
  // ----------------------------------------------------------------
  // trade-off: zero wait states, but a read right behind a write
  // to the same word returns the value before that write
  logic [31:0] next_rdata;

  always_comb
  begin
    next_rdata = 32'h0;
    case (haddr_i[7:0])
      OFS_CMD:     next_rdata = {28'h0, last_cmd};
      OFS_LAT:     next_rdata = 32'(cur_lat);
      OFS_LON:     next_rdata = 32'(cur_lon);
      OFS_FIX:     next_rdata = {31'h0, fresh_fix};
      OFS_VEH:     next_rdata = {5'h0, gps_stat, 2'h0, speed, rssi, batt};
      OFS_AGE:     next_rdata = 32'(fix_age);
      OFS_STATE:   next_rdata = {19'h0, stat_req, pos_req, report_valid_o,
                                 ant_ok, crash_high, crash_low,
                                 fence_viol, starter_enable_o,
                                 door_unlock_o, 1'b0, fence_sel};
      OFS_ORG_LAT: next_rdata = 32'(org_lat);
      OFS_ORG_LON: next_rdata = 32'(org_lon);
      OFS_RPT_LO:  next_rdata = report_data_o[31:0];
      OFS_RPT_HI:  next_rdata = {19'h0, report_data_o[RPT_W-1:32]};
      default:     next_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      hrdata_o <= 32'h0;
    else if (ce_i && aph_take && !hwrite_i)
      hrdata_o <= next_rdata;
  end

endmodule

/* File: tch_checker_sva.sv */
// Purpose: port checks for the command handler
// Assumes: one clock, synchronous active-high reset
// Notes:   attached by the bind at the foot
`timescale 1ns/1ps
module tch_checker
  import tch_pkg::*;
#(
  parameter int DOOR_CYC = 20
)(
  // clock and control
  input wire logic             clk_sys_i,
  input wire logic             reset_i,
  input wire logic             ce_i,
  // commands and relays
  input wire logic             cmd_valid_i,
  input wire logic [3:0]       cmd_id_i,
  input wire logic             door_unlock_o,
  input wire logic             starter_enable_o,
  // report
  input wire logic             report_valid_o,
  input wire logic [RPT_W-1:0] report_data_o,
  input wire logic             report_ready_i
);
  // ----------------
  // helpers
  // ----------------
  logic [31:0] door_len;
  logic        take;
  logic        st_new;

  assign take   = cmd_valid_i && ce_i;
  assign st_new = report_valid_o && report_data_o[RPT_W-1];

  // high-cycle count, judged when the pulse falls
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i || !door_unlock_o)
      door_len <= '0;
    else if (ce_i)
      door_len <= door_len + 32'h1;
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);

  // ----------------
  // assertions
  // ----------------
  AST_POS_REPLY: assert property (
    take && cmd_id_i == CMD_POSITION |-> ##[2:60] report_valid_o && !report_data_o[RPT_W-1])
    else $error("no position report");
  AST_STAT_REPLY: assert property (
    take && cmd_id_i == CMD_STATUS |-> ##[2:60] st_new)
    else $error("no status report");
  AST_DOOR_ON: assert property (
    take && cmd_id_i == CMD_DOOR |=> door_unlock_o)
    else $error("door pulse missing");
  AST_DOOR_LEN: assert property (
    $fell(door_unlock_o) |-> door_len >= DOOR_CYC)
    else $error("door pulse short");
  AST_START_OFF: assert property (
    take && cmd_id_i == CMD_START_OFF |=> !starter_enable_o)
    else $error("starter not off");
  AST_START_ON: assert property (
    take && cmd_id_i == CMD_START_ON |=> starter_enable_o)
    else $error("starter not on");
  AST_RPT_HOLD: assert property (
    report_valid_o && !report_ready_i |=> report_valid_o && $stable(report_data_o))
    else $error("report changed while waiting");
  AST_RPT_GAP: assert property (
    report_valid_o && report_ready_i |=> !report_valid_o)
    else $error("report valid after accept");
  AST_STAT_FLAGS: assert property (
    $rose(report_valid_o) && st_new
      |-> report_data_o[3:2] == {$past(door_unlock_o), $past(starter_enable_o)})
    else $error("door or starter flag wrong");
  AST_UNARMED: assert property (
    $rose(report_valid_o) && st_new && report_data_o[7:5] == FENCE_NONE |-> !report_data_o[4])
    else $error("violation with no fence");
endmodule

bind tch_command_handler tch_checker #(.DOOR_CYC(DOOR_CYC)) chk_u (
  .clk_sys_i, .reset_i, .ce_i, .cmd_valid_i, .cmd_id_i, .door_unlock_o,
  .starter_enable_o, .report_valid_o, .report_data_o, .report_ready_i
);

/* File: tch_host_model.sv */
// Purpose: remote host: pages commands, takes reports
// Assumes: same clock as the device
// Notes:   stall_cyc slows acceptance of reports
`timescale 1ns/1ps
module tch_host_model
  import tch_pkg::*;
#(
  parameter int REPLY_WIN = 100
)(
  // clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             reset_i,
  // paging
  output logic                  cmd_valid_o = 1'b0,
  output logic [3:0]            cmd_id_o = 4'hf,
  // reports
  input  wire logic             report_valid_i,
  input  wire logic [RPT_W-1:0] report_data_i,
  output logic                  report_ready_o = 1'b0
);
  int               stall_cyc = 0;
  int               wait_cnt;
  int               rpt_cnt;
  int               reply_age;
  logic             diag_flag;
  logic [RPT_W-1:0] last_rpt;

  task automatic send(input logic [3:0] id);
    @(posedge clk_sys_i);
    cmd_valid_o <= 1'b1;
    cmd_id_o    <= id;
    @(posedge clk_sys_i);
    cmd_valid_o <= 1'b0;
    // idle id lines never repeat the last command
    cmd_id_o    <= ~id;
  endtask

  always @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      report_ready_o <= 1'b0;
      wait_cnt       <= 0;
      rpt_cnt        <= 0;
    end
    else if (report_valid_i && report_ready_o)
    begin
      last_rpt       <= report_data_i;
      rpt_cnt        <= rpt_cnt + 1;
      report_ready_o <= 1'b0;
      wait_cnt       <= 0;
    end
    else if (report_valid_i && wait_cnt >= stall_cyc)
      report_ready_o <= 1'b1;
    else if (report_valid_i)
      wait_cnt <= wait_cnt + 1;
  end

  always @(posedge clk_sys_i)
  begin
    if (reset_i || (report_valid_i && report_ready_o && !report_data_i[RPT_W-1]))
      reply_age <= 0;
    else if (cmd_valid_o && cmd_id_o == CMD_POSITION)
      reply_age <= 1;
    else if (reply_age != 0)
      reply_age <= reply_age + 1;
    diag_flag <= !reset_i && (diag_flag || reply_age > REPLY_WIN);
  end
endmodule

/* File: tb_top.sv */
// Purpose: self-checking bench for the command handler
// Assumes: host model pages commands and takes reports
// Notes:   door and antenna times shortened by parameter
`timescale 1ns/1ps
module tb_top;
  import tch_pkg::*;
  localparam int DOOR_N = 20;
  localparam int ANT_N  = 30;

  logic             clk_sys_i = 1'b0;
  logic             reset_i = 1'b1;
  logic             ce_i = 1'b1;
  logic             hsel_i = 1'b0;
  logic [31:0]      haddr_i = 32'h0;
  logic [1:0]       htrans_i = 2'h0;
  logic             hwrite_i = 1'b0;
  logic [2:0]       hsize_i = 3'h2;
  logic [31:0]      hwdata_i = 32'h0;
  logic             fence_violation_i = 1'b0;
  logic             antenna_ok_i = 1'b1;
  logic             crash_low_i = 1'b0;
  logic             crash_high_i = 1'b0;
  logic [31:0]      hrdata_o;
  logic             hreadyout_o;
  logic             hresp_o;
  logic             door_unlock_o;
  logic             starter_enable_o;
  logic             report_valid_o;
  logic             report_ready_i;
  logic             cmd_valid_i;
  logic [3:0]       cmd_id_i;
  logic [RPT_W-1:0] report_data_o;
  logic [31:0]      q;
  int               n;
  int               c;
  int               n_fail = 0;
  int               cmp_count = 0;

  always #50 clk_sys_i = ~clk_sys_i;

  tch_command_handler #(.DOOR_CYC(DOOR_N), .ANT_CYC(ANT_N)) dut_u (
    .clk_sys_i, .reset_i, .ce_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
    .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
    .cmd_valid_i, .cmd_id_i, .fence_violation_i, .antenna_ok_i, .crash_low_i,
    .crash_high_i, .door_unlock_o, .starter_enable_o, .report_valid_o,
    .report_data_o, .report_ready_i
  );

  tch_host_model host_u (
    .clk_sys_i, .reset_i, .cmd_valid_o(cmd_valid_i), .cmd_id_o(cmd_id_i),
    .report_valid_i(report_valid_o), .report_data_i(report_data_o),
    .report_ready_o(report_ready_i)
  );

  task automatic test_done();
    $display("TB: %0d compares, %0d mismatches", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [RPT_W-1:0] got, input logic [RPT_W-1:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // no cycle limit here: the watchdog ends a hung bus
  task automatic wait_ready();
    do
      @(posedge clk_sys_i);
    while (hreadyout_o !== 1'b1);
  endtask

  // one single-word transfer; read data lands in q
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    hsel_i   <= 1'b1;
    haddr_i  <= {24'h0, a};
    htrans_i <= 2'h2;
    hwrite_i <= wr;
    wait_ready();
    hsel_i   <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    wait_ready();
    q = hrdata_o;
  endtask

  task automatic wait_rpt(input int cnt);
    for (int i = 0; i < 100 && host_u.rpt_cnt == cnt; i++)
      @(posedge clk_sys_i);
  endtask

  task automatic rpt(input logic [3:0] id, input logic [RPT_W-1:0] exp);
    c = host_u.rpt_cnt;
    host_u.send(id);
    wait_rpt(c);
    check(host_u.last_rpt, exp);
  endtask

  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    bus(1'b0, 8'h80, 32'h0);
    check(RPT_W'(q), '0);
    check(RPT_W'(hresp_o), '0);
    bus(1'b1, OFS_LAT, 32'h001a_5a5a);
    bus(1'b1, OFS_LON, 32'h002c_3c3c);
    bus(1'b1, OFS_FIX, 32'h1);
    rpt(CMD_POSITION, {ID_POS, 21'h1a5a5a, 22'h2c3c3c, 1'b1});
    rpt(CMD_POSITION, {ID_POS, 21'h1a5a5a, 22'h2c3c3c, 1'b0});
    host_u.send(CMD_DOOR);
    @(negedge clk_sys_i);
    n = 0;
    while (door_unlock_o === 1'b1 && n < 100)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    check(RPT_W'(n), RPT_W'(DOOR_N));
    host_u.send(CMD_START_OFF);
    @(negedge clk_sys_i);
    check(RPT_W'(starter_enable_o), '0);
    host_u.send(4'h0);
    host_u.send(4'hc);
    @(negedge clk_sys_i);
    check(RPT_W'({starter_enable_o, door_unlock_o}), '0);
    host_u.send(CMD_START_ON);
    @(negedge clk_sys_i);
    check(RPT_W'(starter_enable_o), RPT_W'(1'b1));
    // a command written over the bus runs one edge after its data phase
    bus(1'b1, OFS_CMD, 32'(CMD_START_OFF));
    repeat (2) @(negedge clk_sys_i);
    check(RPT_W'(starter_enable_o), '0);
    host_u.send(CMD_START_ON);
    @(negedge clk_sys_i);
    check(RPT_W'(starter_enable_o), RPT_W'(1'b1));
    for (int k = 1; k <= 3; k++)
    begin
      bus(1'b1, OFS_LAT, 32'(k) * 32'h1100);
      bus(1'b1, OFS_LON, 32'(k) * 32'h2200);
      host_u.send(CMD_START_ON + 4'(k));
      bus(1'b0, OFS_ORG_LAT, 32'h0);
      check(RPT_W'(q), RPT_W'(32'(k) * 32'h1100));
      bus(1'b0, OFS_ORG_LON, 32'h0);
      check(RPT_W'(q), RPT_W'(32'(k) * 32'h2200));
      bus(1'b0, OFS_STATE, 32'h0);
      check(RPT_W'(q[2:0]), RPT_W'(k));
    end
    bus(1'b1, OFS_VEH, 32'h052b_5e9c);
    bus(1'b1, OFS_AGE, 32'h0000_05a3);
    fence_violation_i <= 1'b1;
    crash_low_i       <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    // slow host keeps the word waiting
    host_u.stall_cyc = 6;
    rpt(CMD_STATUS, {ID_STATUS, 8'h9c, 8'h5e, 6'h2b, 11'h5a3, 3'h5, 3'h3, 5'b10110});
    host_u.stall_cyc = 0;
    host_u.send(CMD_FENCE_OFF);
    bus(1'b0, OFS_STATE, 32'h0);
    check(RPT_W'(q[2:0]), '0);
    antenna_ok_i <= 1'b0;
    repeat (ANT_N + 10) @(posedge clk_sys_i);
    c = host_u.rpt_cnt;
    antenna_ok_i <= 1'b1;
    wait_rpt(c);
    check(RPT_W'({host_u.last_rpt[RPT_W-1], host_u.last_rpt[7:4]}), RPT_W'(5'h10));
    check(RPT_W'(host_u.diag_flag), '0);
    test_done();
  end

  initial
  begin
    repeat (5000) @(posedge clk_sys_i);
    n_fail++;
    test_done();
  end
endmodule
